// File: verilog/omv_pkg.sv
// Package: register map, field positions, reset values, timing for omv block
package omv_pkg;
  // Register indices (printed offsets are not all multiples of four)
  localparam logic [7:0] OMV_IDX_PWR1  = 8'h01;
  localparam logic [7:0] OMV_IDX_PWR3  = 8'h03;
  localparam logic [7:0] OMV_IDX_ADDC  = 8'h07;
  localparam logic [7:0] OMV_IDX_SPKMX = 8'h32;
  localparam logic [7:0] OMV_IDX_SPKVC = 8'h36;
  localparam logic [7:0] OMV_IDX_MONMX = 8'h38;
  // Own register: live state readback
  localparam logic [7:0] OMV_IDX_STAT  = 8'h3f;
  localparam int OMV_RW = 9;
  // Reset values
  localparam logic [8:0] OMV_RST_PWR1  = 9'h000;
  localparam logic [8:0] OMV_RST_PWR3  = 9'h000;
  localparam logic [8:0] OMV_RST_ADDC  = 9'h000;
  localparam logic [8:0] OMV_RST_SPKMX = 9'h000;
  localparam logic [8:0] OMV_RST_SPKVC = 9'h079;
  localparam logic [8:0] OMV_RST_MONMX = 9'h000;
  // Field positions
  localparam int OMV_B_BIAS   = 3;
  localparam int OMV_B_BUFIO  = 2;
  localparam int OMV_B_MONEN  = 7;
  localparam int OMV_B_SPKN   = 6;
  localparam int OMV_B_SPKP   = 5;
  localparam int OMV_B_MONMIX = 3;
  localparam int OMV_B_SPKMIX = 2;
  localparam int OMV_B_SLOW   = 0;
  localparam int OMV_B_AUXSPK = 5;
  localparam int OMV_B_BYPSPK = 1;
  localparam int OMV_B_DACSPK = 0;
  localparam int OMV_B_SPKATT = 8;
  localparam int OMV_B_SPEAKER_GAIN_ON_CROSSING  = 7;
  localparam int OMV_B_SPKMUT = 6;
  localparam int OMV_B_MONATT = 7;
  localparam int OMV_B_MONMUT = 6;
  localparam int OMV_B_AUXMON = 2;
  localparam int OMV_B_BYPMON = 1;
  localparam int OMV_B_DACMON = 0;
  // Gain code: 0x39 is 0 dB, 1 dB per step
  localparam logic [5:0] OMV_GAIN_0DB = 6'h39;
  // Timing: 200 MHz clock, slow clock period 2^21 cycles
  localparam int OMV_CLK_HZ     = 200000000;
  localparam int OMV_SLOW_LOG2  = 21;
  localparam int OMV_TOUT_HZ    = 31;
  // Timeout in slow ticks is at least one
  localparam int OMV_TOUT_TICKS = 1;
  localparam int OMV_CLK_PER_TOUT = OMV_CLK_HZ / OMV_TOUT_HZ;
endpackage : omv_pkg

// File: verilog/omv_zc_gain.sv
// Zero-cross gated gain stage holding the applied speaker gain
`timescale 1ns/1ps
`default_nettype none
module omv_zc_gain #(
  parameter int W = 6,
  parameter int SW = 16,
  parameter logic [5:0] RST = 6'h39
) (
  // Clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // Control
  input  wire logic [W-1:0]  target,
  input  wire logic          on_crossing,
  input  wire logic          sample_valid,
  input  wire logic [SW-1:0] sample,
  input  wire logic          timeout_tick,
  // Applied gain
  output logic      [W-1:0]  applied
);
  logic          prev_sign;
  logic          next_prev_sign;
  logic [W-1:0]  next_applied;
  logic          crossing;

  always_comb
  begin
    next_prev_sign = prev_sign;
    next_applied   = applied;
    crossing = sample_valid && (sample[SW-1] != prev_sign);
    if (sample_valid)
      next_prev_sign = sample[SW-1];
    if (!on_crossing)
      next_applied = target;
    else if (crossing || timeout_tick)
      next_applied = target;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_sign <= 1'b0;
      applied   <= RST;
    end
    else
    begin
      prev_sign <= next_prev_sign;
      applied   <= next_applied;
    end
  end

  property p_immediate;
    @(posedge hclk) disable iff (!hresetn)
      !on_crossing |=> applied == $past(target);
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("gain not applied at once");

  property p_hold;
    @(posedge hclk) disable iff (!hresetn)
      (on_crossing && !sample_valid && !timeout_tick) |=> $stable(applied);
  endproperty
  a_hold: assert property (p_hold)
    else $error("gain changed without crossing");
endmodule : omv_zc_gain
`default_nettype wire

// File: verilog/omv_top.sv
// Output mixer and volume control register bank with AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Speaker mixer sums selected DAC, bypass, aux
// - Speaker gain 6-bit, 1 dB steps
// - Speaker mute resets set, keeps mid level
// - Negative speaker carries inverted positive signal
// - Speaker bypass attenuate picks 0 or -10 dB
// - Zero-cross bit defers speaker gain update
// - Pending gain applies after slow timeout
// - Slow clock enable gates the gain timeout
// - Mono mixer sums selected DAC, bypass, aux
// - Mono bypass attenuate picks 0 or -10 dB
// - Mono mute drives mid reference level
// - Output and mixer enables reset off
// - Bias and midref buffer enables in power one
// - Slow clock period is 2^21 cycles
module omv_top
  import omv_pkg::*;
#(
  parameter int SLOW_LOG2 = omv_pkg::OMV_SLOW_LOG2,
  parameter int SW        = 16
) (
  // Clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // AHB-Lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  // Signal feeding the speaker gain stage
  input  wire logic          sample_valid,
  input  wire logic [SW-1:0] sample,
  // Analogue speaker path controls
  output logic [2:0]         speaker_sources,
  output logic               speaker_bypass_attenuate,
  output logic [5:0]         speaker_gain_code,
  output logic               speaker_silence,
  output logic               speaker_negative_invert,
  output logic               speaker_positive_enable,
  output logic               speaker_negative_enable,
  output logic               speaker_mixer_enable,
  // Analogue mono path controls
  output logic [2:0]         single_sources,
  output logic               single_bypass_attenuate,
  output logic               single_out_silence,
  output logic               single_out_enable,
  output logic               single_mixer_enable,
  // Bias and slow clock
  output logic               amplifier_bias_enable,
  output logic               midref_buffer_enable,
  output logic               slow_tick
);
  import omv_pkg::*;

  // ------------------------------------------------
  // Registers and bus state
  // ------------------------------------------------
  logic [8:0] pwr1, pwr3, addc, spkmx, spkvc, monmx;
  logic [8:0] next_pwr1, next_pwr3, next_addc;
  logic [8:0] next_spkmx, next_spkvc, next_monmx;
  logic       wr_pend, next_wr_pend;
  logic [7:0] wr_idx, next_wr_idx;
  logic [31:0] next_hrdata;
  logic [SLOW_LOG2-1:0] slow_cnt, next_slow_cnt;
  logic       next_slow_tick;
  logic [5:0] applied_gain;
  logic       addr_ph;
  logic [7:0] a_idx;

  assign addr_ph = hsel && hready && htrans[1];
  assign a_idx   = haddr[9:2];

  function automatic logic [31:0] rd_mux(input logic [7:0] idx,
                                         input logic [8:0] p1,
                                         input logic [8:0] p3,
                                         input logic [8:0] ad,
                                         input logic [8:0] sm,
                                         input logic [8:0] sv,
                                         input logic [8:0] mm,
                                         input logic [5:0] ag);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (idx)
      OMV_IDX_PWR1:  r = {23'h0, p1};
      OMV_IDX_PWR3:  r = {23'h0, p3};
      OMV_IDX_ADDC:  r = {23'h0, ad};
      OMV_IDX_SPKMX: r = {23'h0, sm};
      OMV_IDX_SPKVC: r = {23'h0, sv};
      OMV_IDX_MONMX: r = {23'h0, mm};
      OMV_IDX_STAT:  r = {26'h0, ag};
      default:       r = 32'h0000_0000;
    endcase
    return r;
  endfunction : rd_mux

  // ------------------------------------------------
  // Bus and register write
  // ------------------------------------------------
  always_comb
  begin
    next_pwr1    = pwr1;
    next_pwr3    = pwr3;
    next_addc    = addc;
    next_spkmx   = spkmx;
    next_spkvc   = spkvc;
    next_monmx   = monmx;
    next_wr_pend = 1'b0;
    next_wr_idx  = wr_idx;
    next_hrdata  = hrdata;
    if (wr_pend)
    begin
      case (wr_idx)
        OMV_IDX_PWR1:  next_pwr1  = hwdata[8:0];
        OMV_IDX_PWR3:  next_pwr3  = hwdata[8:0];
        OMV_IDX_ADDC:  next_addc  = hwdata[8:0];
        OMV_IDX_SPKMX: next_spkmx = hwdata[8:0];
        OMV_IDX_SPKVC: next_spkvc = hwdata[8:0];
        OMV_IDX_MONMX: next_monmx = hwdata[8:0];
        default:       next_pwr1  = pwr1;
      endcase
    end
    if (addr_ph)
    begin
      next_wr_pend = hwrite;
      next_wr_idx  = a_idx;
      // Read data reflects a write landing in the same cycle
      if (!hwrite)
        next_hrdata = rd_mux(a_idx, next_pwr1, next_pwr3, next_addc,
                             next_spkmx, next_spkvc, next_monmx,
                             applied_gain);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pwr1    <= OMV_RST_PWR1;
      pwr3    <= OMV_RST_PWR3;
      addc    <= OMV_RST_ADDC;
      spkmx   <= OMV_RST_SPKMX;
      spkvc   <= OMV_RST_SPKVC;
      monmx   <= OMV_RST_MONMX;
      wr_pend <= 1'b0;
      wr_idx  <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end
    else
    begin
      pwr1    <= next_pwr1;
      pwr3    <= next_pwr3;
      addc    <= next_addc;
      spkmx   <= next_spkmx;
      spkvc   <= next_spkvc;
      monmx   <= next_monmx;
      wr_pend <= next_wr_pend;
      wr_idx  <= next_wr_idx;
      hrdata  <= next_hrdata;
    end
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ------------------------------------------------
  // Slow clock divider
  // ------------------------------------------------
  // Stopped and cleared while disabled, so no timeout can fire
  always_comb
  begin
    next_slow_cnt  = '0;
    next_slow_tick = 1'b0;
    if (addc[OMV_B_SLOW])
    begin
      next_slow_cnt  = slow_cnt + 1'b1;
      next_slow_tick = &slow_cnt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      slow_cnt  <= '0;
      slow_tick <= 1'b0;
    end
    else
    begin
      slow_cnt  <= next_slow_cnt;
      slow_tick <= next_slow_tick;
    end
  end

  // ------------------------------------------------
  // Speaker gain stage
  // ------------------------------------------------
  omv_zc_gain #(
    .W   (6),
    .SW  (SW),
    .RST (OMV_GAIN_0DB)
  ) u_spk_gain (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .target       (spkvc[5:0]),
    .on_crossing  (spkvc[OMV_B_SPEAKER_GAIN_ON_CROSSING]),
    .sample_valid (sample_valid),
    .sample       (sample),
    .timeout_tick (slow_tick),
    .applied      (applied_gain)
  );

  // ------------------------------------------------
  // Output controls, all registered
  // ------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      speaker_sources          <= 3'h0;
      speaker_bypass_attenuate <= 1'b0;
      speaker_gain_code        <= OMV_GAIN_0DB;
      speaker_silence          <= 1'b1;
      speaker_negative_invert  <= 1'b1;
      speaker_positive_enable  <= 1'b0;
      speaker_negative_enable  <= 1'b0;
      speaker_mixer_enable     <= 1'b0;
      single_sources           <= 3'h0;
      single_bypass_attenuate  <= 1'b0;
      single_out_silence       <= 1'b0;
      single_out_enable        <= 1'b0;
      single_mixer_enable      <= 1'b0;
      amplifier_bias_enable    <= 1'b0;
      midref_buffer_enable     <= 1'b0;
    end
    else
    begin
      speaker_sources <= {spkmx[OMV_B_AUXSPK], spkmx[OMV_B_BYPSPK],
                          spkmx[OMV_B_DACSPK]};
      speaker_bypass_attenuate <= spkvc[OMV_B_SPKATT];
      speaker_gain_code        <= applied_gain;
      speaker_silence          <= spkvc[OMV_B_SPKMUT];
      speaker_negative_invert  <= 1'b1;
      speaker_positive_enable  <= pwr3[OMV_B_SPKP];
      speaker_negative_enable  <= pwr3[OMV_B_SPKN];
      speaker_mixer_enable     <= pwr3[OMV_B_SPKMIX];
      single_sources <= {monmx[OMV_B_AUXMON], monmx[OMV_B_BYPMON],
                         monmx[OMV_B_DACMON]};
      single_bypass_attenuate  <= monmx[OMV_B_MONATT];
      single_out_silence       <= monmx[OMV_B_MONMUT];
      single_out_enable        <= pwr3[OMV_B_MONEN];
      single_mixer_enable      <= pwr3[OMV_B_MONMIX];
      amplifier_bias_enable    <= pwr1[OMV_B_BIAS];
      midref_buffer_enable     <= pwr1[OMV_B_BUFIO];
    end
  end

  // ------------------------------------------------
  // Checks
  // ------------------------------------------------
  sequence s_wr_spkvc;
    addr_ph && hwrite && a_idx == OMV_IDX_SPKVC;
  endsequence

  property p_spk_mute;
    @(posedge hclk) disable iff (!hresetn)
      s_wr_spkvc ##1 1'b1 |-> ##2 speaker_silence == $past(hwdata[6], 2);
  endproperty
  a_spk_mute: assert property (p_spk_mute)
    else $error("speaker mute not following write");

  property p_no_tick_off;
    @(posedge hclk) disable iff (!hresetn)
      !addc[OMV_B_SLOW] |=> !slow_tick;
  endproperty
  a_no_tick_off: assert property (p_no_tick_off)
    else $error("slow tick while disabled");

  property p_tick_period;
    @(posedge hclk) disable iff (!hresetn)
      slow_tick |-> slow_cnt == '0 && $past(slow_cnt) == '1
        && $past(addc[OMV_B_SLOW]);
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("slow tick misaligned");

  property p_invert;
    @(posedge hclk) disable iff (!hresetn) speaker_negative_invert;
  endproperty
  a_invert: assert property (p_invert)
    else $error("negative speaker not inverted");

  property p_spk_src;
    @(posedge hclk) disable iff (!hresetn)
      ##1 speaker_sources == $past({spkmx[5], spkmx[1], spkmx[0]});
  endproperty
  a_spk_src: assert property (p_spk_src)
    else $error("speaker sources wrong");

  property p_mon_src;
    @(posedge hclk) disable iff (!hresetn)
      ##1 single_sources == $past(monmx[2:0]);
  endproperty
  a_mon_src: assert property (p_mon_src)
    else $error("mono sources wrong");

  property p_att;
    @(posedge hclk) disable iff (!hresetn)
      ##1 speaker_bypass_attenuate == $past(spkvc[8])
        && single_bypass_attenuate == $past(monmx[7]);
  endproperty
  a_att: assert property (p_att)
    else $error("attenuation wrong");

  property p_enables;
    @(posedge hclk) disable iff (!hresetn)
      ##1 single_out_enable == $past(pwr3[7])
        && midref_buffer_enable == $past(pwr1[2]);
  endproperty
  a_enables: assert property (p_enables)
    else $error("enables wrong");

  property p_mono_mute;
    @(posedge hclk) disable iff (!hresetn)
      ##1 single_out_silence == $past(monmx[6]);
  endproperty
  a_mono_mute: assert property (p_mono_mute)
    else $error("mono mute wrong");
endmodule : omv_top
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking testbench for the output mixer and volume register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import omv_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int SLOW = 4;
  localparam int SP   = 1 << SLOW;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        sample_valid;
  logic [15:0] sample;
  logic [2:0]  spk_src;
  logic [2:0]  mono_src;
  logic        spk_att;
  logic        spk_mute;
  logic        spk_inv;
  logic [5:0]  gain;
  wire  [4:0]  enables;
  logic        mono_att;
  logic        mono_mute;
  logic        bias_en;
  logic        buf_en;
  logic        slow_tick;
  int          n_errors;
  int          tests_run;

  omv_top #(.SLOW_LOG2(SLOW), .SW(16)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sample_valid(sample_valid), .sample(sample),
    .speaker_sources(spk_src), .speaker_bypass_attenuate(spk_att),
    .speaker_gain_code(gain), .speaker_silence(spk_mute),
    .speaker_negative_invert(spk_inv),
    .speaker_positive_enable(enables[2]),
    .speaker_negative_enable(enables[3]),
    .speaker_mixer_enable(enables[0]), .single_sources(mono_src),
    .single_bypass_attenuate(mono_att), .single_out_silence(mono_mute),
    .single_out_enable(enables[4]), .single_mixer_enable(enables[1]),
    .amplifier_bias_enable(bias_en), .midref_buffer_enable(buf_en),
    .slow_tick(slow_tick)
  );

  // ------------------------------------------------------------
  // Common tasks
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // Single AHB-Lite word transfer; byte address is four times the index
  task automatic ahb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {22'h000000, idx, 2'b00};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wr ? wd : 32'h00000000;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask : ahb

  task automatic wr(input logic [7:0] idx, input logic [8:0] d);
    logic [31:0] rd;
    ahb(1'b1, idx, {23'h0, d}, rd);
    repeat (2) @(negedge hclk);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] idx,
                        input logic [31:0] exp);
    logic [31:0] rd;
    ahb(1'b0, idx, 32'h0, rd);
    check(nm, rd, exp);
  endtask : rd_chk

  task automatic wait_gain(input logic [5:0] exp, input int lim);
    int k;
    for (k = 0; k < lim && gain !== exp; k++)
      @(negedge hclk);
    check("gain", {26'h0, gain}, {26'h0, exp});
  endtask : wait_gain

  task automatic pulse(input logic [15:0] s);
    @(posedge hclk);
    sample_valid <= 1'b1;
    sample       <= s;
    @(posedge hclk);
    sample_valid <= 1'b0;
    repeat (4) @(negedge hclk);
  endtask : pulse

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    check("spk_src", {29'h0, spk_src}, 32'h0);
    check("gain", {26'h0, gain}, 32'h39);
    check("spk_mute", {31'h0, spk_mute}, 32'h1);
    check("spk_inv", {31'h0, spk_inv}, 32'h1);
    check("spk_att", {31'h0, spk_att}, 32'h0);
    check("mono_src", {29'h0, mono_src}, 32'h0);
    check("mono_att", {31'h0, mono_att}, 32'h0);
    check("mono_mute", {31'h0, mono_mute}, 32'h0);
    check("enables", {27'h0, enables}, 32'h0);
    check("bias", {30'h0, bias_en, buf_en}, 32'h0);
    rd_chk("pwr1", OMV_IDX_PWR1, 32'h0);
    rd_chk("pwr3", OMV_IDX_PWR3, 32'h0);
    rd_chk("addc", OMV_IDX_ADDC, 32'h0);
    rd_chk("spkmx", OMV_IDX_SPKMX, 32'h0);
    rd_chk("spkvc", OMV_IDX_SPKVC, 32'h079);
    rd_chk("monmx", OMV_IDX_MONMX, 32'h0);
  endtask : t_reset

  task automatic t_mixers;
    int i;
    int sb[3] = '{0, 1, 5};
    for (i = 0; i < 3; i++)
    begin
      wr(OMV_IDX_SPKMX, 9'(1 << sb[i]));
      check("spk_src", {29'h0, spk_src}, 32'(1 << i));
      wr(OMV_IDX_MONMX, 9'(1 << i));
      check("mono_src", {29'h0, mono_src}, 32'(1 << i));
    end
    wr(OMV_IDX_SPKMX, 9'h023);
    check("spk_src", {29'h0, spk_src}, 32'h7);
    wr(OMV_IDX_MONMX, 9'h0c7);
    check("mono_src", {29'h0, mono_src}, 32'h7);
    check("mono_att", {31'h0, mono_att}, 32'h1);
    check("mono_mute", {31'h0, mono_mute}, 32'h1);
    rd_chk("monmx", OMV_IDX_MONMX, 32'h0c7);
    wr(OMV_IDX_MONMX, 9'h000);
    check("mono_mute", {31'h0, mono_mute}, 32'h0);
  endtask : t_mixers

  task automatic t_power;
    int i;
    int pb[5] = '{2, 3, 5, 6, 7};
    // Mid buffer on before any output, else pops
    wr(OMV_IDX_PWR1, 9'h004);
    check("bias", {30'h0, bias_en, buf_en}, 32'h1);
    for (i = 0; i < 5; i++)
    begin
      wr(OMV_IDX_PWR3, 9'(1 << pb[i]));
      check("enables", {27'h0, enables}, 32'(1 << i));
    end
    wr(OMV_IDX_PWR1, 9'h00c);
    check("bias", {30'h0, bias_en, buf_en}, 32'h3);
    wr(OMV_IDX_PWR1, 9'h004);
    check("bias", {30'h0, bias_en, buf_en}, 32'h1);
    rd_chk("pwr3", OMV_IDX_PWR3, 32'h080);
  endtask : t_power

  task automatic t_gain_now;
    int i;
    logic [5:0] g[3] = '{6'h3f, 6'h00, 6'h39};
    wr(OMV_IDX_SPKVC, 9'h100 | 9'(g[0]));
    check("spk_mute", {31'h0, spk_mute}, 32'h0);
    check("spk_att", {31'h0, spk_att}, 32'h1);
    for (i = 0; i < 3; i++)
    begin
      wr(OMV_IDX_SPKVC, 9'(g[i]));
      wait_gain(g[i], 4);
      rd_chk("status", OMV_IDX_STAT, 32'(g[i]));
    end
    check("spk_inv", {31'h0, spk_inv}, 32'h1);
  endtask : t_gain_now

  // Slow clock is still off here, so only a crossing may apply the gain
  task automatic t_zero_cross;
    wr(OMV_IDX_SPKVC, 9'h0b9);
    wr(OMV_IDX_SPKVC, 9'h0a0);
    repeat (3 * SP) @(negedge hclk);
    check("gain", {26'h0, gain}, 32'h39);
    pulse(16'h0100);
    check("gain", {26'h0, gain}, 32'h39);
    pulse(16'hff00);
    wait_gain(6'h20, 2);
  endtask : t_zero_cross

  task automatic t_timeout;
    int k;
    int ticks;
    wr(OMV_IDX_ADDC, 9'h001);
    wr(OMV_IDX_SPKVC, 9'h0bf);
    wait_gain(6'h3f, 2 * SP + 8);
    for (k = 0; k < 2 * SP && slow_tick !== 1'b1; k++)
      @(negedge hclk);
    @(negedge hclk);
    for (k = 1; k < 2 * SP && slow_tick !== 1'b1; k++)
      @(negedge hclk);
    check("tick_period", 32'(k), 32'(SP));
    wr(OMV_IDX_ADDC, 9'h000);
    wr(OMV_IDX_SPKVC, 9'h085);
    ticks = 0;
    repeat (3 * SP)
    begin
      @(negedge hclk);
      if (slow_tick !== 1'b0)
        ticks++;
    end
    check("ticks_off", 32'(ticks), 32'h0);
    check("gain", {26'h0, gain}, 32'h3f);
  endtask : t_timeout

  task automatic t_unmapped;
    wr(8'h10, 9'h1ff);
    rd_chk("unmapped", 8'h10, 32'h0);
    rd_chk("pwr1", OMV_IDX_PWR1, 32'h004);
  endtask : t_unmapped

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  initial
  begin
    #20000;
    n_errors++;
    finish_test();
  end

  initial
  begin
    n_errors     = 0;
    tests_run    = 0;
    hresetn      = 1'b0;
    hsel         = 1'b0;
    haddr        = 32'h0;
    htrans       = 2'b00;
    hwrite       = 1'b0;
    hsize        = 3'b010;
    hwdata       = 32'h0;
    sample_valid = 1'b0;
    sample       = 16'h0000;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    t_reset();
    t_mixers();
    t_power();
    t_gain_now();
    t_zero_cross();
    t_timeout();
    t_unmapped();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
